// File: design/cbtse_regs.sv
/*
  CAN nominal bit timing, timestamp, timeout and error status registers
  with their counters, behind an APB slave.
  Assumes the protocol engine, the control register holding the unlock
  and hold bits, and the FIFOs all run on pclk.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (R1) Timing register writable only when unlocked and held
// (R2) Quantum is prescaler plus one clocks
// (R3) Bit is seg1 plus seg2 plus three
// (R4) Sampled bit ready edge after sample
// (R5) Prescaler in 24:16, used plus one
// (R6) Jump, seg1, seg2 fields used plus one; jump_width is not used by the logic
// (R7) Timing register resets to 500k default
// (R8) Stamp prescaler sets unit, 1-16 bits
// (R9) Timestamp source decode, external select overrides
// (R10) Capture timestamp at start of frame
// (R11) Wrap flag on nonzero-to-zero, not write
// (R12) Write clears internal count; external ignores
// (R13) Timeout period start value; enable bit
// (R14) Continuous preset on write; FIFO mode
// (R15) Decrement per unit; flag and stop
// (R16) Log count on error increments, bus-off
// (R17) Log clears on read, saturates, overflow
// (R18) Passive flag, receive and transmit counts
// (R19) Restricted mode freezes counters, logs errors
// (R20) Secondary sample position, saturated at 127
// (R21) Exception flag, cleared by status read
// (R22) FD frame flags loaded, cleared on read
// (R23) Event flags sticky, write one clears
// (R24) Protected writes need unlock and hold
module cbtse_regs
  import cbtse_pkg::*;
(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  input  wire logic [3:0]    pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Control bits
  input  wire logic          config_write_unlock,
  input  wire logic          config_hold_mode,
  input  wire logic          restricted_operation,
  input  wire logic          external_stamp_select,
  input  wire logic [15:0]   ext_stamp,
  input  wire logic [6:0]    secondary_sample_offset,
  // Protocol engine and FIFOs
  input  wire cbtse_err_ev_s err_ev,
  input  wire cbtse_frm_ev_s frm_ev,
  input  wire logic [2:0]    fifo_empty,
  input  wire logic [2:0]    fifo_store,
  input  wire logic          bus_rx_pin,
  // Timing and status out
  output logic               tq_tick,
  output logic               sample_tick,
  output logic               bit_tick,
  output logic               sampled_bit,
  output logic [15:0]        stamp_capture,
  output logic               bus_off
);

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction

  cbtse_nbt_s  nbt;
  cbtse_tsc_s  timestamp_count;
  cbtse_toc_s  timeout_remaining;
  cbtse_to_e   to_st;
  logic [15:0] ts_cnt;
  logic [15:0] to_cnt;
  logic [2:0]  evt;
  logic [7:0]  transmit_error_count;
  logic [6:0]  rx_error_count;
  logic        rp;
  logic [7:0]  error_log_count;
  logic [6:0]  secondary_sample_position;
  logic        protocol_exception_flag, fdf, last_rx_rate_switch, last_rx_error_state_ind;
  logic        ready_q, miss_q;
  logic [8:0]  qcnt;
  logic [9:0]  tqcnt;
  logic [3:0]  ucnt;
  logic        unit_tick;
  logic        rx_s1, rx_s2;
  logic [31:0] next_rdata;
  logic        next_miss;
  logic        acc, wr, rd;
  logic        ts_ext, ts_wr, to_wr;
  logic [15:0] ts_view;
  logic        cel_inc, to_empty, to_store;
  logic [8:0]  tec_sum;
  logic [7:0]  rec_sum, tdc_sum;
  logic [2:0]  evt_set;

  // One wait state so read data comes from a flip-flop
  assign pready  = ready_q;
  assign pslverr = ready_q & miss_q;
  assign acc     = psel & penable & ready_q;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;

  always_comb begin
    next_miss  = 1'b0;
    next_rdata = 32'h0000_0000;
    case (paddr)
      ADR_NBT: next_rdata = nbt;
      ADR_TSC: next_rdata = timestamp_count;
      ADR_TSV: next_rdata = {16'h0000, ts_view};
      ADR_TOC: next_rdata = timeout_remaining;
      ADR_TOV: next_rdata = {16'h0000, to_cnt};
      ADR_EVT: next_rdata = {29'h0000_0000, evt};
      ADR_ECR: next_rdata = {8'h00, error_log_count, rp, rx_error_count, transmit_error_count};                    // R18
      ADR_PSR: next_rdata = {9'h000, secondary_sample_position, 1'b0, protocol_exception_flag, fdf, last_rx_rate_switch, last_rx_error_state_ind, 11'h000};
      default: next_miss = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      miss_q  <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      ready_q <= psel & penable & ~ready_q;
      if (psel & penable & ~ready_q) begin
        miss_q <= next_miss;
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end
    end
  end

  // Protected timing register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      nbt <= NBT_RST;                                                      // R7
    else if (wr && paddr == ADR_NBT && config_write_unlock && config_hold_mode)  // R1 R24
      nbt <= wmerge(nbt, pwdata, pstrb);                                   // R5 R6
  end

  // Other configuration registers, also protected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timestamp_count <= '0;
      timeout_remaining <= TOC_RST;
    end else if (wr && config_write_unlock && config_hold_mode) begin      // R24
      if (paddr == ADR_TSC)
        timestamp_count <= wmerge(timestamp_count, pwdata, pstrb);
      if (paddr == ADR_TOC)
        timeout_remaining <= wmerge(timeout_remaining, pwdata, pstrb);                                 // R13
    end
  end

  // Quantum and bit timing; halted while held in configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt    <= '0;
      tq_tick <= 1'b0;
    end else if (config_hold_mode) begin
      qcnt    <= '0;
      tq_tick <= 1'b0;
    end else begin
      tq_tick <= (qcnt == nbt.quantum_prescaler);                          // R2
      qcnt    <= (qcnt == nbt.quantum_prescaler) ? 9'd0 : qcnt + 9'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tqcnt       <= '0;
      sample_tick <= 1'b0;
      bit_tick    <= 1'b0;
    end else begin
      sample_tick <= tq_tick && tqcnt == {2'b00, nbt.seg_before_sample} + 10'd1;
      bit_tick    <= tq_tick && tqcnt == {2'b00, nbt.seg_before_sample}
                     + {3'b000, nbt.seg_after_sample} + 10'd2;             // R3
      if (config_hold_mode)
        tqcnt <= '0;
      else if (tq_tick)
        tqcnt <= (tqcnt == {2'b00, nbt.seg_before_sample}
                  + {3'b000, nbt.seg_after_sample} + 10'd2) ? 10'd0 : tqcnt + 10'd1;
    end
  end

  // Bus pin synchroniser and sampled value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1       <= 1'b1;
      rx_s2       <= 1'b1;
      sampled_bit <= 1'b1;
    end else begin
      rx_s1 <= bus_rx_pin;
      rx_s2 <= rx_s1;
      if (sample_tick)
        sampled_bit <= rx_s2;                                              // R4
    end
  end

  // Time unit of stamp and timeout counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ucnt      <= '0;
      unit_tick <= 1'b0;
    end else begin
      unit_tick <= bit_tick && ucnt == timestamp_count.stamp_prescaler;                // R8
      if (bit_tick)
        ucnt <= (ucnt == timestamp_count.stamp_prescaler) ? 4'd0 : ucnt + 4'd1;
    end
  end

  // Timestamp counter
  assign ts_ext  = external_stamp_select || timestamp_count.timestamp_source == TSS_EXT;
  assign ts_view = ts_ext ? ext_stamp : ts_cnt;                            // R9
  assign ts_wr   = wr && paddr == ADR_TSV && !ts_ext;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ts_cnt <= '0;
    else if (ts_ext || timestamp_count.timestamp_source != TSS_INT || ts_wr)
      ts_cnt <= '0;                                                        // R9 R12
    else if (unit_tick)
      ts_cnt <= ts_cnt + 16'd1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stamp_capture <= '0;
    else if (frm_ev.sof)
      stamp_capture <= ts_view;                                            // R10
  end

  // Timeout counter
  assign to_wr    = wr && paddr == ADR_TOV;
  assign to_empty = timeout_remaining.timeout_source != TOS_CONT && fifo_empty[timeout_remaining.timeout_source - 2'd1];
  assign to_store = timeout_remaining.timeout_source != TOS_CONT && fifo_store[timeout_remaining.timeout_source - 2'd1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_st  <= TO_IDLE;
      to_cnt <= TOV_RST;
    end else if (!timeout_remaining.timeout_enable_bit) begin
      to_st <= TO_IDLE;                                                    // R13
    end else if (timeout_remaining.timeout_source == TOS_CONT && to_wr) begin
      to_cnt <= timeout_remaining.timeout_period;                                        // R14
      to_st  <= TO_RUN;
    end else if (to_empty) begin
      to_cnt <= timeout_remaining.timeout_period;                                        // R14
      to_st  <= TO_IDLE;
    end else begin
      case (to_st)
        TO_IDLE: if (timeout_remaining.timeout_source == TOS_CONT || to_store) to_st <= TO_RUN;
        TO_RUN: begin
          if (to_cnt == 16'd0)
            to_st <= TO_DONE;
          else if (unit_tick) begin
            to_cnt <= to_cnt - 16'd1;                                      // R15
            if (to_cnt == 16'd1)
              to_st <= TO_DONE;
          end
        end
        TO_DONE: to_st <= TO_DONE;
        default: to_st <= TO_IDLE;
      endcase
    end
  end

  // Error counters
  assign tec_sum = {1'b0, transmit_error_count} + {5'd0, err_ev.tx_add};
  assign rec_sum = {1'b0, rx_error_count} + {4'd0, err_ev.rx_add};
  // Passive flag alone, with receive count unchanged, is not logged
  assign cel_inc = (err_ev.tx_err && (tec_sum <= 9'h0FF || !bus_off))
                   || (err_ev.rx_err && rec_sum < REC_PASS);                // R16 R19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_error_count     <= '0;
      rx_error_count     <= '0;
      rp      <= 1'b0;
      bus_off <= 1'b0;
    end else if (err_ev.clear) begin
      transmit_error_count     <= '0;
      rx_error_count     <= '0;
      rp      <= 1'b0;
      bus_off <= 1'b0;
    end else if (!restricted_operation) begin                              // R19
      if (err_ev.tx_err) begin
        if (tec_sum > 9'h0FF)
          bus_off <= 1'b1;
        else
          transmit_error_count <= tec_sum[7:0];
      end else if (err_ev.tx_ok && transmit_error_count != 8'd0)
        transmit_error_count <= transmit_error_count - 8'd1;
      if (err_ev.rx_err) begin
        if (rec_sum >= REC_PASS)
          rp <= 1'b1;                                                      // R18
        else
          rx_error_count <= rec_sum[6:0];
      end else if (err_ev.rx_ok) begin
        if (rp)
          rp <= 1'b0;
        else if (rx_error_count != 7'd0)
          rx_error_count <= rx_error_count - 7'd1;
      end
    end
  end

  // Logging count; below CEL_MAX an increment beats the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      error_log_count <= '0;
    else if (cel_inc && error_log_count != CEL_MAX)
      error_log_count <= (rd && paddr == ADR_ECR) ? 8'd1 : error_log_count + 8'd1;                 // R16
    else if (rd && paddr == ADR_ECR)
      error_log_count <= '0;                                                           // R17
  end

  // Protocol status; whole-word read clears byte 1 flags
  assign tdc_sum = {1'b0, frm_ev.tdc_meas} + {1'b0, secondary_sample_offset};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_sample_position <= '0;
      protocol_exception_flag  <= 1'b0;
      fdf  <= 1'b0;
      last_rx_rate_switch <= 1'b0;
      last_rx_error_state_ind <= 1'b0;
    end else begin
      if (frm_ev.tdc_valid)
        secondary_sample_position <= (tdc_sum > TDC_MAX) ? TDC_MAX[6:0] : tdc_sum[6:0];         // R20
      if (frm_ev.protocol_exception_flag)
        protocol_exception_flag <= 1'b1;                                                       // R21
      else if (rd && paddr == ADR_PSR)
        protocol_exception_flag <= 1'b0;
      if (frm_ev.fd_rx) begin
        fdf  <= 1'b1;                                                      // R22
        last_rx_rate_switch <= frm_ev.brs;
        last_rx_error_state_ind <= frm_ev.esi;
      end else if (rd && paddr == ADR_PSR) begin
        fdf  <= 1'b0;
        last_rx_rate_switch <= 1'b0;
        last_rx_error_state_ind <= 1'b0;
      end
    end
  end

  // Sticky event flags, set beats write-one clear
  always_comb begin
    evt_set           = 3'b000;
    evt_set[EVT_WRAP] = unit_tick && !ts_ext && timestamp_count.timestamp_source == TSS_INT
                        && ts_cnt == TS_MAX && !ts_wr;                     // R11
    evt_set[EVT_TOUT] = timeout_remaining.timeout_enable_bit && to_st == TO_RUN
                        && unit_tick && to_cnt == 16'd1;                   // R15
    evt_set[EVT_ELO]  = cel_inc && error_log_count == CEL_MAX;                         // R17
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      evt <= '0;
    else if (wr && paddr == ADR_EVT && pstrb[0])
      evt <= (evt & ~pwdata[2:0]) | evt_set;                               // R23
    else
      evt <= evt | evt_set;                                                // R23
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_to_last;
    to_st == TO_RUN && unit_tick && to_cnt == 16'd1;
  endsequence

  a_nbt_locked: assert property (!(config_write_unlock && config_hold_mode) |=> $stable(nbt)) // R1
    else $error("timing register changed while locked");
  a_tq_spacing: assert property ($rose(tq_tick) && !config_hold_mode && nbt.quantum_prescaler == 9'd1
                                 |=> !tq_tick ##1 tq_tick || config_hold_mode || $changed(nbt)) // R2
    else $error("quantum spacing wrong");
  a_wrap_flag: assert property (evt_set[EVT_WRAP] |=> evt[EVT_WRAP] && ts_cnt == 16'd0) // R11
    else $error("wrap flag not set");
  a_stamp_clear: assert property (ts_wr |=> ts_cnt == 16'd0 && !evt_set[EVT_WRAP]) // R12
    else $error("timestamp write did not clear");
  a_tout_stop: assert property (s_to_last and timeout_remaining.timeout_enable_bit && !to_wr && !to_empty
                                |=> to_st == TO_DONE && evt[EVT_TOUT] ##1 $stable(to_cnt)) // R15
    else $error("timeout did not stop");
  a_log_clear: assert property (rd && paddr == ADR_ECR && !cel_inc |=> error_log_count == 8'd0) // R17
    else $error("log count not cleared");
  a_log_sat: assert property (error_log_count == CEL_MAX && cel_inc |=> error_log_count == CEL_MAX && evt[EVT_ELO]) // R17
    else $error("log count saturation wrong");
  a_restricted: assert property (restricted_operation && !err_ev.clear |=> $stable(transmit_error_count) && $stable(rx_error_count)) // R19
    else $error("counters moved in restricted mode");
  a_fd_load: assert property (frm_ev.fd_rx |=> fdf && last_rx_rate_switch == $past(frm_ev.brs) && last_rx_error_state_ind == $past(frm_ev.esi)) // R22
    else $error("fd flags not loaded");
  a_tdc_range: assert property (frm_ev.tdc_valid |=> secondary_sample_position <= TDC_MAX[6:0]) // R20
    else $error("secondary sample position out of range");

endmodule

`default_nettype wire

// File: design/cbtse_pkg.sv
/*
  Shared constants and carriers for the CAN bit timing, timestamp,
  timeout and error status register block.
  Assumes a 32-bit APB master and a protocol engine on the same clock.
*/
package cbtse_pkg;
  // Register byte addresses
  localparam logic [11:0] ADR_NBT  = 12'h01C;
  localparam logic [11:0] ADR_TSC  = 12'h020;
  localparam logic [11:0] ADR_TSV  = 12'h024;
  localparam logic [11:0] ADR_TOC  = 12'h028;
  localparam logic [11:0] ADR_TOV  = 12'h02C;
  localparam logic [11:0] ADR_EVT  = 12'h030;
  localparam logic [11:0] ADR_ECR  = 12'h040;
  localparam logic [11:0] ADR_PSR  = 12'h044;
  // Reset values
  localparam logic [31:0] NBT_RST  = 32'h0600_0A03;
  localparam logic [31:0] TOC_RST  = 32'hFFFF_0000;
  localparam logic [15:0] TOV_RST  = 16'hFFFF;
  // Limits and codes
  localparam logic [7:0]  REC_PASS = 8'h80;
  localparam logic [7:0]  CEL_MAX  = 8'hFF;
  localparam logic [7:0]  TDC_MAX  = 8'h7F;
  localparam logic [15:0] TS_MAX   = 16'hFFFF;
  localparam logic [1:0]  TSS_INT  = 2'b01;
  localparam logic [1:0]  TSS_EXT  = 2'b10;
  localparam logic [1:0]  TOS_CONT = 2'b00;
  localparam int unsigned EVT_WRAP = 0;
  localparam int unsigned EVT_TOUT = 1;
  localparam int unsigned EVT_ELO  = 2;

  typedef struct packed {
    logic [6:0] jump_width;
    logic [8:0] quantum_prescaler;
    logic [7:0] seg_before_sample;
    logic       rsv;
    logic [6:0] seg_after_sample;
  } cbtse_nbt_s;

  typedef struct packed {
    logic [11:0] rsv_hi;
    logic [3:0]  stamp_prescaler;
    logic [13:0] rsv_lo;
    logic [1:0]  timestamp_source;
  } cbtse_tsc_s;

  typedef struct packed {
    logic [15:0] timeout_period;
    logic [12:0] rsv;
    logic [1:0]  timeout_source;
    logic        timeout_enable_bit;
  } cbtse_toc_s;

  // Error events from the protocol engine
  typedef struct packed {
    logic       tx_err;
    logic [3:0] tx_add;
    logic       rx_err;
    logic [3:0] rx_add;
    logic       tx_ok;
    logic       rx_ok;
    logic       clear;
  } cbtse_err_ev_s;

  // Frame events from the protocol engine
  typedef struct packed {
    logic       sof;
    logic       fd_rx;
    logic       brs;
    logic       esi;
    logic       protocol_exception_flag;
    logic       tdc_valid;
    logic [6:0] tdc_meas;
  } cbtse_frm_ev_s;

  typedef enum logic [2:0] {
    TO_IDLE = 3'b001,
    TO_RUN  = 3'b010,
    TO_DONE = 3'b100
  } cbtse_to_e;
endpackage

// File: test/cbtse_bus_model.sv
/*
  CAN bus seen through the transceiver's receive side.
  Assumes the bench decides when a far node holds the bus dominant.
*/
`timescale 1ns/1ps
`default_nettype none

module cbtse_bus_model (
  // Bench control
  input  wire logic dominant,
  // Receive pin
  output logic      bus_rx_pin
);
  // Released bus floats recessive through the termination
  assign bus_rx_pin = dominant ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// File: test/tb.sv
/*
  Self-checking bench for the CAN timing, stamp, timeout and error registers.
  Assumes one pclk domain and the one-wait-state APB slave of the design.
*/
`timescale 1ns/1ps
`default_nettype none

module tb
  import cbtse_pkg::*;
;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0000_0000;
  logic [31:0]   prdata;
  logic          pready, pslverr;
  logic          unlock = 1'b0, hold = 1'b0, restr = 1'b0, ext_sel = 1'b0;
  logic [15:0]   ext_stamp = 16'h5A3C;
  logic [6:0]    ssp_off = 7'h32;
  cbtse_err_ev_s err_ev = '0;
  cbtse_frm_ev_s frm_ev = '0;
  logic          dominant = 1'b0;
  logic          bus_rx_pin, tq_tick, sample_tick, bit_tick, sampled_bit, bus_off;
  logic [15:0]   stamp_capture;
  int            err_count = 0;
  int            checks = 0;
  logic [31:0]   r, r2;
  logic          e;
  int            n;

  always #5 pclk = ~pclk;

  cbtse_regs cbtse_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .config_write_unlock(unlock), .config_hold_mode(hold),
    .restricted_operation(restr), .external_stamp_select(ext_sel), .ext_stamp(ext_stamp),
    .secondary_sample_offset(ssp_off), .err_ev(err_ev), .frm_ev(frm_ev), .fifo_empty(3'b111),
    .fifo_store(3'b000), .bus_rx_pin(bus_rx_pin), .tq_tick(tq_tick), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .sampled_bit(sampled_bit), .stamp_capture(stamp_capture), .bus_off(bus_off));

  cbtse_bus_model cbtse_bus_model_i (.dominant(dominant), .bus_rx_pin(bus_rx_pin));

  task summarize;
    begin
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        err_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // Request held until pready seen high; answer taken in that cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
           output logic er);
    int k;
    begin
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) chk(32'h0000_0000, 32'h0000_0001);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        y;
    begin
      apb(1'b1, a, d, x, y);
    end
  endtask

  task rd(input logic [11:0] a, output logic [31:0] d);
    logic y;
    begin
      apb(1'b0, a, 32'h0000_0000, d, y);
    end
  endtask

  // Clocks between two ticks: sel 0 quantum, 1 bit
  task gap(input logic sel, output int m);
    begin
      @(negedge pclk);
      while ((sel ? bit_tick : tq_tick) !== 1'b1) @(negedge pclk);
      m = 0;
      do begin
        @(negedge pclk);
        m++;
      end while ((sel ? bit_tick : tq_tick) !== 1'b1 && m < 3000);
    end
  endtask

  task err_pulse(input logic tx, input logic [3:0] add);
    cbtse_err_ev_s v;
    begin
      v = '0;
      if (tx) begin
        v.tx_err = 1'b1;
        v.tx_add = add;
      end else begin
        v.rx_err = 1'b1;
        v.rx_add = add;
      end
      @(posedge pclk);
      err_ev <= v;
      @(posedge pclk);
      err_ev <= '0;
    end
  endtask

  task frm_pulse(input cbtse_frm_ev_s v);
    begin
      @(posedge pclk);
      frm_ev <= v;
      @(posedge pclk);
      frm_ev <= '0;
    end
  endtask

  initial begin
    #100us;
    chk(32'h0000_0000, 32'h0000_0001);
    summarize();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADR_NBT, r); chk(r, 32'h0600_0A03);
    rd(ADR_TOC, r); chk(r, TOC_RST);
    apb(1'b0, 12'h100, 32'h0000_0000, r, e); chk({31'h0000_0000, e}, 32'h0000_0001);
    wr(ADR_NBT, 32'h0001_0201);
    rd(ADR_NBT, r); chk(r, 32'h0600_0A03);
    unlock <= 1'b1;
    wr(ADR_NBT, 32'h0001_0201);
    rd(ADR_NBT, r); chk(r, 32'h0600_0A03);
    hold <= 1'b1;
    wr(ADR_NBT, 32'h0001_0201);
    rd(ADR_NBT, r); chk(r, 32'h0001_0201);
    wr(ADR_TSC, 32'h0000_0001);
    wr(ADR_TOC, 32'h0003_0001);
    @(posedge pclk);
    hold <= 1'b0;
    // Two clocks a quantum, 2+1+3 quanta a bit
    gap(1'b0, n); chk(n, 32'd2);
    gap(1'b1, n); chk(n, 32'd12);
    @(posedge pclk);
    dominant <= 1'b1;
    repeat (3) gap(1'b1, n);
    chk({31'h0000_0000, sampled_bit}, 32'h0000_0000);
    @(posedge pclk);
    dominant <= 1'b0;
    repeat (3) gap(1'b1, n);
    chk({31'h0000_0000, sampled_bit}, 32'h0000_0001);
    // Stamp advances one per bit; a window allows for read latency
    rd(ADR_TSV, r);
    repeat (240) @(posedge pclk);
    rd(ADR_TSV, r2);
    n = int'(r2[15:0]) - int'(r[15:0]);
    chk({31'h0000_0000, n >= 19 && n <= 21}, 32'h0000_0001);
    wr(ADR_TSV, 32'h0000_0000);
    rd(ADR_TSV, r); chk({31'h0000_0000, r[15:0] <= 16'h0001}, 32'h0000_0001);
    rd(ADR_EVT, r); chk(r & 32'h0000_0001, 32'h0000_0000);
    // Timeout of three bit units after a preset
    wr(ADR_TOV, 32'h0000_0000);
    repeat (80) @(posedge pclk);
    rd(ADR_TOV, r); chk({16'h0000, r[15:0]}, 32'h0000_0000);
    rd(ADR_EVT, r); chk(r & 32'h0000_0002, 32'h0000_0002);
    wr(ADR_EVT, 32'h0000_0000);
    rd(ADR_EVT, r); chk(r & 32'h0000_0002, 32'h0000_0002);
    wr(ADR_EVT, 32'h0000_0002);
    rd(ADR_EVT, r); chk(r & 32'h0000_0002, 32'h0000_0000);
    wr(ADR_TOV, 32'h0000_0000);
    rd(ADR_TOV, r); chk({31'h0000_0000, r[15:0] >= 16'h0002}, 32'h0000_0001);
    // External stamp mirrored, writes ignored, captured at frame start
    ext_sel <= 1'b1;
    rd(ADR_TSV, r); chk({16'h0000, r[15:0]}, 32'h0000_5A3C);
    wr(ADR_TSV, 32'h0000_0000);
    rd(ADR_TSV, r); chk({16'h0000, r[15:0]}, 32'h0000_5A3C);
    frm_pulse(13'h1000);
    @(posedge pclk);
    @(negedge pclk);
    chk({16'h0000, stamp_capture}, 32'h0000_5A3C);
    ext_sel <= 1'b0;
    // Error counters and logging
    err_pulse(1'b1, 4'h8);
    rd(ADR_ECR, r); chk(r, 32'h0001_0008);
    rd(ADR_ECR, r); chk(r, 32'h0000_0008);
    restr <= 1'b1;
    err_pulse(1'b1, 4'h8);
    rd(ADR_ECR, r); chk(r, 32'h0001_0008);
    restr <= 1'b0;
    // Nine receive errors of 15: the last only sets the passive flag
    repeat (9) err_pulse(1'b0, 4'hF);
    rd(ADR_ECR, r); chk(r, 32'h0008_F808);
    // FD frame, exception and delay measurement of 100 plus 50
    frm_pulse(13'h0DE4);
    rd(ADR_PSR, r); chk(r & 32'h007F_7800, 32'h007F_7000);
    rd(ADR_PSR, r); chk(r & 32'h007F_7800, 32'h007F_0000);
    summarize();
  end
endmodule

`default_nettype wire
